// ===== gpfc_port.sv
// Purpose: six-pin port, data/direction/pull-up, falling-edge port interrupt, pin function select
// Assumes: register port strobes synchronous to clk; pin inputs synchronous to clk
// Notes:   all outputs registered; edge sampling and request setting advance on the system-clock enable (clk / 4)
`timescale 1ns/10ps
`include "gpfc_defines.svh"

// What this block does
// - two data registers hold pin levels; two direction registers choose per-bit mode
// - direction 0 means input, 1 output; all inputs after reset
// - input pin with data bit 1 enables pull-up; open-drain pin has none
// - port-A bit 3 only pulls low, needs external pull-up for high
// - only pins configured as inputs raise the port interrupt
// - falling input edge sets request flag; both enables raise CPU request
// - select-0 bit 1: oscillator-input pin as port-B bit 1 or disabled
// - select-0 bit 3: oscillator-output pin as port-B bit 0 or disabled
// - select-1 bit 0: reset-shared pin as port-A bit 3 or disabled
// - select-1 bits 3-2: 00 port-A bit 2, 10 timer clock, x1 disabled
// - select-2 bits 1-0: sixth pin is port-A bit 1 only when 00
// - select-2 bit 3: seventh pin as port-A bit 0 or disabled
// - every reset clears data, direction, function, enable and request bits
// - unimplemented register bits read as zero
// - external RC frees port-B bit 0; internal RC frees both oscillator pins
// - oscillator and reset pin uses fixed by options; rest chosen at run time
// - edge sampling and request flags run on a system clock of oscillator frequency over four
module gpfc_port (
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	input  wire gpfc_pkg::gpfc_osc_t         oscOption,
	input  wire logic                        pinResetEnable,
	input  wire logic [`GPFC_ADDR_W-1:0]     regAddr,
	input  wire logic [`GPFC_DATA_W-1:0]     regWrData,
	input  wire logic                        regWrite,
	input  wire logic                        regRead,
	output logic      [`GPFC_DATA_W-1:0]     regRdData,
	input  wire logic [3:0]                  portAIn,
	output logic      [3:0]                  portAOut,
	output logic      [3:0]                  portAOe,
	output logic      [3:0]                  portAPullUp,
	input  wire logic [1:0]                  portBIn,
	output logic      [1:0]                  portBOut,
	output logic      [1:0]                  portBOe,
	output logic      [1:0]                  portBPullUp,
	output logic                             externalTimerClockInput,
	output logic                             cpuPortIrqRequest
);
	logic [3:0] portADataReg;
	logic [1:0] portBDataReg;
	logic [3:0] portADirReg;
	logic [1:0] portBDirReg;
	logic       portIrqEnableReg;
	logic       portIrqRequestReg;
	logic       cpuPortIrqEnableReg;
	logic       cpuPortIrqRequestReg;
	logic [3:0] funcSel0Reg;
	logic [3:0] funcSel1Reg;
	logic [3:0] funcSel2Reg;
	logic [1:0] divCountReg;
	logic       sysTick;
	logic [5:0] pinLevelReg;
	logic [5:0] pinLevelNow;
	logic [5:0] pinIsIo;
	logic [5:0] pinDir;
	logic [5:0] pinData;
	logic [5:0] inputWatch;
	logic       fallSeen;
	logic       oscInIsPort;
	logic       oscOutIsPort;
	logic       resetPinIsPort;
	logic       clrRequest;
	logic       clrCpuRequest;
	logic       wrPortAData;
	logic       wrPortBData;
	logic       wrPortADir;
	logic       wrPortBDir;
	logic       wrFuncSel0;
	logic       wrFuncSel1;
	logic       wrFuncSel2;
	logic       wrIrqEnable;
	logic       wrCpuIrqEnable;
	logic       wrIrqRequest;
	logic       wrCpuIrqRequest;
	logic [3:0] readMux;
	logic [5:0] fallPerPin;

	// system-clock enable, one cycle in four
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			divCountReg <= 2'h0;
		end else begin
			divCountReg <= divCountReg + 2'h1;
		end
	end
	assign sysTick = (divCountReg == 2'(`GPFC_SYS_DIV - 1));

	// oscillator-output pin is a port pin for the RC and clock options, oscillator-input pin for internal RC only
	assign oscInIsPort  = (oscOption == gpfc_pkg::GPFC_OSC_INT_RC);
	assign oscOutIsPort = (oscOption == gpfc_pkg::GPFC_OSC_INT_RC) ||
	                      (oscOption == gpfc_pkg::GPFC_OSC_EXT_RC) ||
	                      (oscOption == gpfc_pkg::GPFC_OSC_EXT_CLK);
	// reset pin use fixed by option, not by software
	assign resetPinIsPort = !pinResetEnable;

	// pin order: 0..3 port-A bits 0..3, 4..5 port-B bits 0..1
	always_comb begin
		pinIsIo = 6'h00;
		pinIsIo[0] = !funcSel2Reg[3];
		// sixth pin needs both bits clear
		pinIsIo[1] = (funcSel2Reg[1:0] == 2'h0);
		// timer-shared pin as port only for 00
		pinIsIo[2] = (funcSel1Reg[3:2] == 2'h0);
		pinIsIo[3] = resetPinIsPort && !funcSel1Reg[0];
		pinIsIo[4] = oscOutIsPort && !funcSel0Reg[3];
		pinIsIo[5] = oscInIsPort && !funcSel0Reg[1];
	end

	assign pinDir      = {portBDirReg, portADirReg};
	assign pinData     = {portBDataReg, portADataReg};
	assign pinLevelNow = {portBIn, portAIn};
	// only port pins set as inputs are watched
	// reassigned pins excluded from edge detection
	assign inputWatch  = pinIsIo & ~pinDir;
	assign fallPerPin  = inputWatch & pinLevelReg & ~pinLevelNow;
	assign fallSeen    = |fallPerPin;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinLevelReg <= 6'h3F;
		end else if (sysTick) begin
			pinLevelReg <= pinLevelNow;
		end
	end

	// register write decode, one strobe per register
	assign wrPortAData     = regWrite && (regAddr == `GPFC_OFF_PORT_A_DATA);
	assign wrPortBData     = regWrite && (regAddr == `GPFC_OFF_PORT_B_DATA);
	assign wrPortADir      = regWrite && (regAddr == `GPFC_OFF_PORT_A_DIR);
	assign wrPortBDir      = regWrite && (regAddr == `GPFC_OFF_PORT_B_DIR);

	assign wrFuncSel0      = regWrite && (regAddr == `GPFC_OFF_FUNC_SEL_0);
	assign wrFuncSel1      = regWrite && (regAddr == `GPFC_OFF_FUNC_SEL_1);
	assign wrFuncSel2      = regWrite && (regAddr == `GPFC_OFF_FUNC_SEL_2);

	// cpu enable and request sit at a local address pair
	assign wrIrqEnable     = regWrite && (regAddr == `GPFC_OFF_IRQ_ENABLE);
	assign wrCpuIrqEnable  = regWrite && (regAddr == `GPFC_OFF_CPU_IRQ);
	assign wrIrqRequest    = regWrite && (regAddr == `GPFC_OFF_IRQ_REQUEST);
	assign wrCpuIrqRequest = regWrite && (regAddr == `GPFC_OFF_CPU_IRQ + 5'h1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portADataReg <= `GPFC_RESET_NIB;
		end else if (wrPortAData) begin
			portADataReg <= regWrData;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portBDataReg <= 2'h0;
		end else if (wrPortBData) begin
			portBDataReg <= regWrData[1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portADirReg <= `GPFC_RESET_NIB;
		end else if (wrPortADir) begin
			portADirReg <= regWrData;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portBDirReg <= 2'h0;
		end else if (wrPortBDir) begin
			portBDirReg <= regWrData[1:0];
		end
	end

	// run-time function select 0, oscillator pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			funcSel0Reg <= `GPFC_RESET_NIB;
		end else if (wrFuncSel0) begin
			funcSel0Reg <= regWrData;
		end
	end

	// select 1 has no bit 1, masked on write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			funcSel1Reg <= `GPFC_RESET_NIB;
		end else if (wrFuncSel1) begin
			funcSel1Reg <= regWrData & `GPFC_FS1_MASK;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			funcSel2Reg <= `GPFC_RESET_NIB;
		end else if (wrFuncSel2) begin
			funcSel2Reg <= regWrData;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portIrqEnableReg <= 1'b0;
		end else if (wrIrqEnable) begin
			portIrqEnableReg <= regWrData[`GPFC_IRQ_BIT];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuPortIrqEnableReg <= 1'b0;
		end else if (wrCpuIrqEnable) begin
			cpuPortIrqEnableReg <= regWrData[`GPFC_CPU_IRQ_BIT];
		end
	end

	// software writes 0 to clear; writing 1 leaves the flag alone
	assign clrRequest    = wrIrqRequest && !regWrData[`GPFC_IRQ_BIT];
	assign clrCpuRequest = wrCpuIrqRequest && !regWrData[`GPFC_CPU_IRQ_BIT];

	// request flags; a new edge wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portIrqRequestReg <= 1'b0;
		end else if (sysTick && fallSeen) begin
			portIrqRequestReg <= 1'b1;
		end else if (clrRequest) begin
			portIrqRequestReg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuPortIrqRequestReg <= 1'b0;
		end else if (sysTick && fallSeen && portIrqEnableReg && cpuPortIrqEnableReg) begin
			cpuPortIrqRequestReg <= 1'b1;
		end else if (clrCpuRequest) begin
			cpuPortIrqRequestReg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuPortIrqRequest <= 1'b0;
		end else begin
			cpuPortIrqRequest <= cpuPortIrqRequestReg && cpuPortIrqEnableReg;
		end
	end

	always_comb begin
		readMux = 4'h0;
		unique case (regAddr)
			`GPFC_OFF_PORT_A_DATA:    readMux = portADataReg;
			`GPFC_OFF_PORT_B_DATA:    readMux = {2'h0, portBDataReg};
			`GPFC_OFF_IRQ_ENABLE:     readMux = {1'b0, portIrqEnableReg, 2'h0};
			`GPFC_OFF_IRQ_REQUEST:    readMux = {1'b0, portIrqRequestReg, 2'h0};
			`GPFC_OFF_FUNC_SEL_0:     readMux = funcSel0Reg;
			`GPFC_OFF_FUNC_SEL_1:     readMux = funcSel1Reg;
			`GPFC_OFF_FUNC_SEL_2:     readMux = funcSel2Reg;
			`GPFC_OFF_PORT_A_DIR:     readMux = portADirReg;
			`GPFC_OFF_PORT_B_DIR:     readMux = {2'h0, portBDirReg};
			`GPFC_OFF_CPU_IRQ:        readMux = {3'h0, cpuPortIrqEnableReg};
			`GPFC_OFF_CPU_IRQ + 5'h1: readMux = {3'h0, cpuPortIrqRequestReg};
			default:                  readMux = 4'h0;
		endcase
	end

	// read data stands one cycle, zero otherwise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdData <= 4'h0;
		end else if (regRead) begin
			regRdData <= readMux;
		end else begin
			regRdData <= 4'h0;
		end
	end

	// open-drain bit never drives a high level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portAOut <= 4'h0;
		end else begin
			portAOut <= portADataReg & 4'h7;
		end
	end

	// direction 1 drives; reassigned pins never driven
	// open-drain bit enabled only to pull low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portAOe <= 4'h0;
		end else begin
			portAOe <= {pinIsIo[3] & portADirReg[3] & !portADataReg[3], pinIsIo[2:0] & portADirReg[2:0]};
		end
	end

	// pull-up on input pins with data 1, never on the open-drain bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portAPullUp <= 4'h0;
		end else begin
			portAPullUp <= pinIsIo[3:0] & ~portADirReg & portADataReg & 4'h7;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portBOut <= 2'h0;
		end else begin
			portBOut <= portBDataReg;
		end
	end

	// oscillator pins not in port use stay released
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portBOe <= 2'h0;
		end else begin
			portBOe <= pinIsIo[5:4] & portBDirReg;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			portBPullUp <= 2'h0;
		end else begin
			portBPullUp <= pinIsIo[5:4] & ~portBDirReg & portBDataReg;
		end
	end

	// timer clock input routed only for code 10
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			externalTimerClockInput <= 1'b0;
		end else begin
			externalTimerClockInput <= (funcSel1Reg[3:2] == 2'h2) && portAIn[2];
		end
	end
endmodule

// ===== gpfc_defines.svh
// Purpose: offsets, field positions and reset values for the pin function port
// Assumes: 4-bit register data, 5-bit register address
// Notes:   definitions only
`ifndef GPFC_DEFINES_SVH
`define GPFC_DEFINES_SVH

`define GPFC_ADDR_W           5
`define GPFC_DATA_W           4
`define GPFC_OFF_PORT_A_DATA  5'h08
`define GPFC_OFF_PORT_B_DATA  5'h09
`define GPFC_OFF_IRQ_ENABLE   5'h0A
`define GPFC_OFF_IRQ_REQUEST  5'h0B
`define GPFC_OFF_FUNC_SEL_0   5'h14
`define GPFC_OFF_FUNC_SEL_1   5'h15
`define GPFC_OFF_FUNC_SEL_2   5'h16
`define GPFC_OFF_PORT_A_DIR   5'h18
`define GPFC_OFF_PORT_B_DIR   5'h19
`define GPFC_OFF_CPU_IRQ      5'h00

`define GPFC_RESET_NIB        4'h0
`define GPFC_PORTB_MASK       4'h3
`define GPFC_FS1_MASK         4'hD
`define GPFC_IRQ_BIT          2
`define GPFC_CPU_IRQ_BIT      0
`define GPFC_OD_BIT           3
`define GPFC_SYS_DIV          4

`endif

// ===== gpfc_pkg.sv
// Purpose: shared types of the pin function port
// Assumes: nothing beyond the defines header
// Notes:   oscillator option codes set at programming time
package gpfc_pkg;
	typedef enum logic [2:0] {
		GPFC_OSC_CRYSTAL  = 3'h0,
		GPFC_OSC_CERAMIC  = 3'h1,
		GPFC_OSC_EXT_RC   = 3'h3,
		GPFC_OSC_INT_RC   = 3'h2,
		GPFC_OSC_EXT_CLK  = 3'h6
	} gpfc_osc_t;
endpackage

// ===== gpfc_port_props.sv
// Purpose: port-level checks of the pin function port
// Assumes: register strobes one cycle wide
// Notes:   bound to gpfc_port, sees its ports only
`timescale 1ns/10ps
module gpfc_port_props (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [4:0] regAddr,
	input wire logic [3:0] regWrData,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [3:0] regRdData,
	input wire logic [3:0] portAIn,
	input wire logic [3:0] portAOut,
	input wire logic [3:0] portAOe,
	input wire logic [3:0] portAPullUp,
	input wire logic [1:0] portBOe,
	input wire logic [1:0] portBPullUp,
	input wire logic       externalTimerClockInput
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_od_out; portAOut[3] == 1'b0; endproperty
	a_od_out: assert property (p_od_out) else $error("open-drain bit driven high");
	property p_od_pu; portAPullUp[3] == 1'b0; endproperty
	a_od_pu: assert property (p_od_pu) else $error("open-drain bit pulled up");
	property p_pu_in; (portAPullUp & portAOe) == 4'h0 && (portBPullUp & portBOe) == 2'h0; endproperty
	a_pu_in: assert property (p_pu_in) else $error("pull-up on driven pin");
	property p_tmr; externalTimerClockInput |-> $past(portAIn[2]); endproperty
	a_tmr: assert property (p_tmr) else $error("timer input not from pin");
	property p_unmap; regRead && regAddr == 5'h0C |=> regRdData == 4'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_rd_idle; !regRead |=> regRdData == 4'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_rsv; regRead && regAddr inside {5'h09, 5'h19} |=> regRdData[3:2] == 2'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("port B upper bits set");
	property p_rsv_irq; regRead && regAddr inside {5'h0A, 5'h0B} |=> (regRdData & 4'hB) == 4'h0; endproperty
	a_rsv_irq: assert property (p_rsv_irq) else $error("irq spare bits set");
	property p_wr_rd;
		regWrite && regAddr inside {5'h08, 5'h14, 5'h16, 5'h18} ##1 regRead && $stable(regAddr)
			|=> regRdData == $past(regWrData, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
endmodule
bind gpfc_port gpfc_port_props props_u (.*);

// ===== gpfc_board.sv
// Purpose: board circuitry on the six shared pins
// Assumes: bits 0-3 port A, bits 4-5 port B
// Notes:   undriven pins without pull-up wander every cycle, except bit 3, which is held high
`timescale 1ns/10ps
module gpfc_board (
	input  wire logic       clk,
	input  wire logic [5:0] pinOut,
	input  wire logic [5:0] pinOe,
	input  wire logic [5:0] pinPullUp,
	input  wire logic [5:0] extDrive,
	input  wire logic [5:0] extLevel,
	output logic      [5:0] pinLevel
);
	logic wanderReg = 1'b0;
	always @(posedge clk) begin
		wanderReg <= !wanderReg;
	end
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pinLevel[i] = pinOe[i] ? pinOut[i] : extDrive[i] ? extLevel[i] : (pinPullUp[i] || i == 3) ? 1'b1 : wanderReg;
		end
	end
endmodule

// ===== gpfc_port_tb_top.sv
// Purpose: self-checking bench of the pin function port
// Assumes: pin vectors hold port A bits 0-3, then port B bits 0-1
// Notes:   random traffic from a fixed seed
`timescale 1ns/10ps
module gpfc_port_tb_top;
	logic                clk = 1'b0;
	logic                arst_n = 1'b0;
	gpfc_pkg::gpfc_osc_t oscOption = gpfc_pkg::GPFC_OSC_INT_RC;
	logic                pinResetEnable = 1'b0;
	logic                regWrite = 1'b0;
	logic                regRead = 1'b0;
	logic [4:0]          regAddr = 5'h00;
	logic [3:0]          regWrData = 4'h0;
	logic [3:0]          regRdData, portAOut, portAOe, portAPullUp, q;
	logic [1:0]          portBOut, portBOe, portBPullUp;
	wire logic [3:0]     portAIn;
	wire logic [1:0]     portBIn;
	logic                externalTimerClockInput, cpuPortIrqRequest;
	logic [5:0]          drv = 6'h3F;
	logic [5:0]          lvl = 6'h3F;
	logic [31:0]         seed = 32'hF603;
	int                  errors = 0;
	int                  checked = 0;
	int                  cycles = 0;
	logic [4:0]          regs [10] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h0C};
	initial begin
		forever #2.5 clk = ~clk;
	end
	gpfc_port dut_u (.clk(clk), .arst_n(arst_n), .oscOption(oscOption), .pinResetEnable(pinResetEnable),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
		.portAPullUp(portAPullUp), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
		.portBPullUp(portBPullUp), .externalTimerClockInput(externalTimerClockInput),
		.cpuPortIrqRequest(cpuPortIrqRequest));
	gpfc_board board_u (.clk, .pinOut({portBOut, portAOut}), .pinOe({portBOe, portAOe}),
		.pinPullUp({portBPullUp, portAPullUp}), .extDrive(drv), .extLevel(lvl), .pinLevel({portBIn, portAIn}));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [3:0] rmask(input logic [4:0] a);
		case (a)
			5'h08, 5'h14, 5'h16, 5'h18: return 4'hF;
			5'h09, 5'h19: return 4'h3;
			5'h0A: return 4'h4;
			5'h15: return 4'hD;
			default: return 4'h0;
		endcase
	endfunction
	// s: A data, A dir, B data, B dir; off: pins taken from the port
	function automatic logic [17:0] exp_pins(input logic [11:0] s, input logic [5:0] off);
		logic [5:0] dat;
		logic [5:0] oe;
		dat = {s[9:8], s[3:0]};
		oe = {s[11:10], s[7:4]} & ~{2'h0, dat[3], 3'h0} & ~off;
		return {oe, dat & oe & 6'h37, ~{s[11:10], s[7:4]} & dat & ~off & 6'h37};
	endfunction
	task automatic check_val(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// write strobe stays up so writes can follow back to back
	task automatic acc(input logic [4:0] a, input logic w, input logic [3:0] d, output logic [3:0] r);
		regAddr <= a;
		regWrData <= d;
		regWrite <= w;
		regRead <= !w;
		@(posedge clk);
		if (!w) begin
			regRead <= 1'b0;
			@(negedge clk);
			r = regRdData;
			@(posedge clk);
		end
	endtask
	task automatic rd_check(input logic [4:0] a, input logic [3:0] exp);
		acc(a, 1'b0, 4'h0, q);
		check_val({2'h0, q}, {2'h0, exp});
	endtask
	task automatic idle(input int n);
		regWrite <= 1'b0;
		regRead <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic cfg(input logic [11:0] s);
		acc(5'h08, 1'b1, s[3:0], q);
		acc(5'h18, 1'b1, s[7:4], q);
		acc(5'h09, 1'b1, {2'h0, s[9:8]}, q);
		acc(5'h19, 1'b1, {2'h0, s[11:10]}, q);
	endtask
	task automatic pins(input logic [11:0] s, input logic [5:0] off);
		logic [17:0] e;
		e = exp_pins(s, off);
		idle(3);
		@(negedge clk);
		check_val({portBOe, portAOe}, e[17:12]);
		check_val({portBOut, portAOut} & {portBOe, portAOe}, e[11:6]);
		check_val({portBPullUp, portAPullUp}, e[5:0]);
		@(posedge clk);
	endtask
	// edge sampling runs at a quarter rate, so allow twelve cycles
	task automatic probe(input logic [5:0] lv, input logic expT, input logic expI);
		lvl <= lv;
		idle(12);
		@(negedge clk);
		check_val({4'h0, externalTimerClockInput, cpuPortIrqRequest}, {4'h0, expT, expI});
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i]) rd_check(regs[i], 4'h0);
		pins(12'h000, 6'h00);
		foreach (regs[i]) begin
			seed = xs(seed);
			acc(regs[i], 1'b1, seed[3:0], q);
			rd_check(regs[i], seed[3:0] & rmask(regs[i]));
		end
		acc(5'h14, 1'b1, 4'h0, q);
		acc(5'h15, 1'b1, 4'h0, q);
		acc(5'h16, 1'b1, 4'h0, q);
		repeat (6) begin
			seed = xs(seed);
			cfg(seed[11:0]);
			pins(seed[11:0], 6'h00);
		end
		cfg(12'h30F);
		pins(12'h30F, 6'h00);
		acc(5'h16, 1'b1, 4'h9, q);
		acc(5'h15, 1'b1, 4'h5, q);
		acc(5'h14, 1'b1, 4'hA, q);
		pins(12'h30F, 6'h3F);
		acc(5'h14, 1'b1, 4'h0, q);
		acc(5'h15, 1'b1, 4'h8, q);
		acc(5'h16, 1'b1, 4'h2, q);
		cfg(12'hFFF);
		pins(12'hFFF, 6'h06);
		probe(6'h3B, 1'b0, 1'b0);
		probe(6'h3F, 1'b1, 1'b0);
		rd_check(5'h0B, 4'h0);
		acc(5'h15, 1'b1, 4'h0, q);
		acc(5'h16, 1'b1, 4'h0, q);
		cfg(12'h000);
		acc(5'h00, 1'b1, 4'h1, q);
		acc(5'h0A, 1'b1, 4'h4, q);
		acc(5'h0B, 1'b1, 4'h0, q);
		probe(6'h3E, 1'b0, 1'b1);
		rd_check(5'h0B, 4'h4);
		acc(5'h0B, 1'b1, 4'h0, q);
		acc(5'h01, 1'b1, 4'h0, q);
		probe(6'h3F, 1'b0, 1'b0);
		cfg(12'h011);
		cfg(12'h010);
		probe(6'h3F, 1'b0, 1'b0);
		rd_check(5'h0B, 4'h0);
		// second reset mid-run, options differ, board lets pins float
		arst_n <= 1'b0;
		oscOption <= gpfc_pkg::GPFC_OSC_EXT_RC;
		pinResetEnable <= 1'b1;
		drv <= 6'h00;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_check(5'h18, 4'h0);
		cfg(12'hCF0);
		pins(12'hCF0, 6'h28);
		close_out();
	end
endmodule
